// >>> vr_ctl_pkg.sv
// constants and types of the regulator control block
`default_nettype none
package vr_ctl_pkg;
    // target voltage is counted in steps of 12.5 mV
    localparam int TGT_W = 8;
    localparam logic [TGT_W-1:0] PAR_HI_BASE = 8'h7C; // 1.5500 V
    localparam logic [TGT_W-1:0] PAR_LO_BASE = 8'h3D; // 0.7625 V
    localparam logic [TGT_W-1:0] BOOT_00 = 8'h58; // 1.1 V
    localparam logic [TGT_W-1:0] BOOT_01 = 8'h50; // 1.0 V
    localparam logic [TGT_W-1:0] BOOT_10 = 8'h48; // 0.9 V
    localparam logic [TGT_W-1:0] BOOT_11 = 8'h40; // 0.8 V

    // clock and timing
    localparam int CLK_MHZ = 100;
    localparam int RAMP_STEP_NS = 1000;
    localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;

    // switching period in clock cycles: 1 MHz .. 100 kHz
    localparam int PER_W = 10;
    localparam int FSW_MIN_KHZ = 100;
    localparam int FSW_MAX_KHZ = 1000;
    localparam logic [PER_W-1:0] PER_MIN = PER_W'(CLK_MHZ * 1000 / FSW_MAX_KHZ);
    localparam logic [PER_W-1:0] PER_MAX = PER_W'(CLK_MHZ * 1000 / FSW_MIN_KHZ);
    localparam logic [PER_W-1:0] PER_RESET = 10'h190;

    // register map (byte addresses)
    localparam logic [3:0] OFS_PERIOD = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_TARGET = 4'h8;

    // status field positions
    localparam int ST_PARALLEL = 0;
    localparam int ST_PGOOD = 1;
    localparam int ST_PHASES = 2;
    localparam int ST_PSAVE = 5;
    localparam int ST_HOST_OK = 6;
    localparam int ST_BRIDGE = 7;
    localparam int ST_TARGET = 8;
    localparam int ST_BOOT = 16;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_RAMP,
        SEQ_GOOD
    } seq_state_t;

    // configuration caught at the enable edge
    typedef struct packed {
        logic parallel_code_mode;
        logic power_saving_cfg;
        logic [2:0] phase_count;
        logic [TGT_W-1:0] startup_voltage_code;
    } session_cfg_t;
endpackage
`default_nettype wire

// >>> vid_code_decode.sv
// identification code to target voltage step decoder
`default_nettype none
module vid_code_decode (
    input wire logic parallel_code_mode,
    input wire logic [5:0] parallel_code_bus,
    input wire logic serial_code_clock,
    input wire logic serial_code_data,
    output logic [vr_ctl_pkg::TGT_W-1:0] target
);
    always_comb begin
        target = '0;
        if (parallel_code_mode) begin
            // strictly linear for every code [R19]
            if (!parallel_code_bus[5]) begin
                target = vr_ctl_pkg::PAR_HI_BASE - {2'b00, parallel_code_bus[4:0], 1'b0}; // [R18]
            end else begin
                target = vr_ctl_pkg::PAR_LO_BASE - {3'b000, parallel_code_bus[4:0]}; // [R18]
            end
        end else begin
            unique case ({serial_code_clock, serial_code_data}) // [R17]
                2'b00: target = vr_ctl_pkg::BOOT_00;
                2'b01: target = vr_ctl_pkg::BOOT_01;
                2'b10: target = vr_ctl_pkg::BOOT_10;
                2'b11: target = vr_ctl_pkg::BOOT_11;
            endcase
        end
    end
endmodule // vid_code_decode
`default_nettype wire

// >>> phase_timebase.sv
// core multiphase and bridge timebase with even phase spacing
`default_nettype none
module phase_timebase #(
    parameter int PHASES_MAX = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic bridge_run,
    input wire logic [vr_ctl_pkg::PER_W-1:0] period,
    input wire logic [2:0] phase_count,
    output logic [PHASES_MAX-1:0] phase_start,
    output logic bridge_start
);
    localparam int W = vr_ctl_pkg::PER_W;
    logic [W-1:0] cnt_reg, cnt_next;
    logic [W-1:0] nb_cnt_reg, nb_cnt_next;
    logic [PHASES_MAX-1:0] start_reg, start_next;
    logic nb_start_reg, nb_start_next;
    logic [W-1:0] slot;
    logic [W-1:0] nb_period;
    logic [W+1:0] nb_scaled;

    always_comb begin
        // spacing of 180, 120 or 90 degrees [R14]
        unique case (phase_count)
            3'd2: slot = period >> 1;
            3'd3: slot = period / W'(3);
            default: slot = period >> 2;
        endcase
        // bridge at 1.25x core rate, own counter so it never locks [R15]
        nb_scaled = ({2'b00, period} * 12'h004) / 12'h005;
        nb_period = nb_scaled[W-1:0];
        cnt_next = (!run || cnt_reg >= period - W'(1)) ? '0 : cnt_reg + W'(1); // [R16]
        nb_cnt_next = (!bridge_run || nb_cnt_reg >= nb_period - W'(1)) ? '0 : nb_cnt_reg + W'(1);
        nb_start_next = bridge_run && nb_cnt_reg == '0; // [R15]
    end

    for (genvar k = 0; k < PHASES_MAX; k++) begin : g_phase
        always_comb begin
            start_next[k] = run && (3'(k) < phase_count) && (cnt_reg == slot * W'(k)); // [R14]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            nb_cnt_reg <= '0;
            start_reg <= '0;
            nb_start_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            nb_cnt_reg <= nb_cnt_next;
            start_reg <= start_next;
            nb_start_reg <= nb_start_next;
        end
    end

    assign phase_start = start_reg;
    assign bridge_start = nb_start_reg;
endmodule // phase_timebase
`default_nettype wire

// >>> vr_mode_startup.sv
// mode selection, startup sequencing and registers of the regulator
`default_nettype none
// What this block does
// R1: sample the mode strap once, at the enable assertion edge.
// R2: strap high selects parallel mode, low serial; host holds strap stable.
// R3: parallel mode takes the core target from the six-bit code bus.
// R4: serial mode uses lines two and three as clock and data only.
// R5: parallel mode keeps the bridge rail off, its output high impedance.
// R6: sample the power-saving strap once after enable and latch it.
// R7: parallel mode decodes the six lines into a stored startup code.
// R8: soft-start ramps the core target gradually up to the startup code.
// R9: power-good rises only after the soft-start ramp completes.
// R10: parallel mode ignores the host power-ok input entirely.
// R11: after power-good in parallel mode, follow each new bus code; codes with line one low decode as serial boot values.
// R12: grounded second and fourth gate outputs reduce phase count before enable.
// R13: board grounds both for two phases, only the fourth for three.
// R14: space phases by 180, 120 or 90 degrees.
// R15: bridge timebase free-runs at 1.25 times the core switching rate.
// R16: per-phase switching frequency is programmable from 100 kHz to 1 MHz.
// R17: serial startup code 00,01,10,11 gives 1.1, 1.0, 0.9, 0.8 V.
// R18: parallel codes step 25 mV from 1.55 V, then 12.5 mV from 0.7625 V.
// R19: decoder is strictly linear; off-pattern table entries are misprints.
// R20: enable low returns to idle, drops power-good, rearms strap sampling.
module vr_mode_startup (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic ENABLE,
    input wire logic [5:0] PARALLEL_CODE_BUS,
    input wire logic POWER_SAVING_STRAP,
    input wire logic HOST_POWER_OK,
    input wire logic [1:0] GATE_SENSE_I,
    output logic [3:0] GATE_O,
    output logic [3:0] GATE_OE,
    output logic BRIDGE_O,
    output logic BRIDGE_OE,
    output logic POWER_GOOD_OUT,
    output logic [vr_ctl_pkg::TGT_W-1:0] CORE_TARGET,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);
    localparam int TW = vr_ctl_pkg::TGT_W;
    localparam int PW = vr_ctl_pkg::PER_W;
    localparam int SW = 6 + 1 + 1 + 1 + 2;

    // reset release
    logic [1:0] rst_sync_reg;
    logic rst_n;
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // two-flop pin synchronisers
    logic [SW-1:0] pin_meta_reg, pin_sync_reg;
    logic en_q;
    logic [5:0] code_s;
    logic psave_s, host_ok_s, en_s;
    logic [1:0] sense_s;
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            en_q <= 1'b0;
        end else begin
            pin_meta_reg <= {ENABLE, PARALLEL_CODE_BUS, POWER_SAVING_STRAP,
                             HOST_POWER_OK, GATE_SENSE_I};
            pin_sync_reg <= pin_meta_reg;
            en_q <= en_s;
        end
    end
    assign {en_s, code_s, psave_s, host_ok_s, sense_s} = pin_sync_reg;

    // line one carries the mode strap, lines two and three the serial clock and data
    logic mode_strap_line, id_line_two, id_line_three;
    assign mode_strap_line = code_s[1];
    assign id_line_two = code_s[2];
    assign id_line_three = code_s[3];

    logic enable_rise;
    assign enable_rise = en_s && !en_q; // [R1]

    // decoded with the strap seen on this same edge
    logic [TW-1:0] decoded;
    vid_code_decode u_decode (
        .parallel_code_mode(mode_strap_line),
        .parallel_code_bus(code_s),
        .serial_code_clock(id_line_two), // [R4]
        .serial_code_data(id_line_three), // [R4]
        .target(decoded)
    );

    // sequencer
    vr_ctl_pkg::seq_state_t state_reg, state_next;
    vr_ctl_pkg::session_cfg_t cfg_reg, cfg_next;
    logic [TW-1:0] target_reg, target_next;
    logic [TW-1:0] goal;
    logic pgood_reg, pgood_next;
    logic [1:0] grounded;
    logic [2:0] detected_phases;
    logic [$clog2(vr_ctl_pkg::RAMP_STEP_CYCLES+1)-1:0] step_cnt_reg, step_cnt_next;
    logic step_tick;

    always_comb begin
        // gate pins are released while idle, so a grounded pin reads low [R12]
        grounded = ~sense_s;
        if (grounded[1]) begin
            detected_phases = grounded[0] ? 3'd2 : 3'd3; // [R12]
        end else begin
            detected_phases = 3'd4; // [R12]
        end
    end

    // one 12.5 mV step per tick keeps the ramp gradual
    always_comb begin
        step_tick = (step_cnt_reg == '0);
        if (state_reg == vr_ctl_pkg::SEQ_IDLE || step_tick) begin
            step_cnt_next = $bits(step_cnt_reg)'(vr_ctl_pkg::RAMP_STEP_CYCLES - 1);
        end else begin
            step_cnt_next = step_cnt_reg - 1'b1;
        end
    end

    always_comb begin
        state_next = state_reg;
        cfg_next = cfg_reg;
        target_next = target_reg;
        pgood_next = pgood_reg;
        goal = cfg_reg.startup_voltage_code;
        unique case (state_reg)
            vr_ctl_pkg::SEQ_IDLE: begin
                target_next = '0;
                pgood_next = 1'b0;
                if (enable_rise) begin
                    cfg_next.parallel_code_mode = mode_strap_line; // [R1] [R2]
                    cfg_next.power_saving_cfg = psave_s; // [R6]
                    cfg_next.phase_count = detected_phases; // [R12]
                    cfg_next.startup_voltage_code = decoded; // [R7] [R17]
                    state_next = vr_ctl_pkg::SEQ_RAMP;
                end
            end
            vr_ctl_pkg::SEQ_RAMP: begin
                if (step_tick && target_reg != goal) begin
                    target_next = target_reg + 1'b1; // [R8]
                end
                if (target_reg == goal) begin
                    // host power-ok plays no part here [R10]
                    state_next = vr_ctl_pkg::SEQ_GOOD;
                    pgood_next = 1'b1; // [R9]
                end
            end
            vr_ctl_pkg::SEQ_GOOD: begin
                if (cfg_reg.parallel_code_mode) begin
                    goal = decoded; // [R3] [R11]
                end
                if (step_tick && target_reg < goal) begin
                    target_next = target_reg + 1'b1; // [R11]
                end else if (step_tick && target_reg > goal) begin
                    target_next = target_reg - 1'b1; // [R11]
                end
            end
        endcase
        if (!en_s) begin
            state_next = vr_ctl_pkg::SEQ_IDLE; // [R20]
            pgood_next = 1'b0; // [R20]
            target_next = '0;
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= vr_ctl_pkg::SEQ_IDLE;
            cfg_reg <= '0;
            target_reg <= '0;
            pgood_reg <= 1'b0;
            step_cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cfg_reg <= cfg_next;
            target_reg <= target_next;
            pgood_reg <= pgood_next;
            step_cnt_reg <= step_cnt_next;
        end
    end

    // timebase
    logic running, bridge_run;
    logic [PW-1:0] period_reg, period_next;
    logic [3:0] phase_start;
    logic bridge_start;
    assign running = state_reg != vr_ctl_pkg::SEQ_IDLE;
    assign bridge_run = running && !cfg_reg.parallel_code_mode; // [R5]

    phase_timebase #(
        .PHASES_MAX(4)
    ) u_timebase (
        .clk(MCLK),
        .rst_n(rst_n),
        .run(running),
        .bridge_run(bridge_run),
        .period(period_reg),
        .phase_count(cfg_reg.phase_count),
        .phase_start(phase_start),
        .bridge_start(bridge_start)
    );

    logic [3:0] gate_oe_next;
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            gate_oe_next[k] = running && (3'(k) < cfg_reg.phase_count);
        end
    end

    logic [3:0] gate_o_reg, gate_oe_reg;
    logic bridge_o_reg, bridge_oe_reg;
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            gate_o_reg <= '0;
            gate_oe_reg <= '0;
            bridge_o_reg <= 1'b0;
            bridge_oe_reg <= 1'b0;
        end else begin
            gate_o_reg <= phase_start & gate_oe_next; // [R14]
            gate_oe_reg <= gate_oe_next; // [R12]
            bridge_o_reg <= bridge_start;
            bridge_oe_reg <= bridge_run; // [R5]
        end
    end

    // avalon slave: one wait state on every access
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic req;
    logic [31:0] status;
    assign req = AVS_READ || AVS_WRITE;

    always_comb begin
        status = '0;
        status[vr_ctl_pkg::ST_PARALLEL] = cfg_reg.parallel_code_mode;
        status[vr_ctl_pkg::ST_PGOOD] = pgood_reg;
        status[vr_ctl_pkg::ST_PHASES +: 3] = cfg_reg.phase_count;
        status[vr_ctl_pkg::ST_PSAVE] = cfg_reg.power_saving_cfg;
        status[vr_ctl_pkg::ST_HOST_OK] = host_ok_s;
        status[vr_ctl_pkg::ST_BRIDGE] = bridge_run;
        status[vr_ctl_pkg::ST_TARGET +: TW] = target_reg;
        status[vr_ctl_pkg::ST_BOOT +: TW] = cfg_reg.startup_voltage_code;
    end

    always_comb begin
        ack_next = req && !ack_reg;
        rdata_next = rdata_reg;
        period_next = period_reg;
        if (req && !ack_reg) begin
            rdata_next = '0;
            unique case (AVS_ADDRESS)
                vr_ctl_pkg::OFS_PERIOD: rdata_next[PW-1:0] = period_reg;
                vr_ctl_pkg::OFS_STATUS: rdata_next = status;
                vr_ctl_pkg::OFS_TARGET: rdata_next[TW-1:0] = target_reg;
                default: rdata_next = '0;
            endcase
        end
        // write lands with waitrequest low
        if (AVS_WRITE && ack_reg && AVS_ADDRESS == vr_ctl_pkg::OFS_PERIOD) begin
            // clamped to the legal band [R16]
            if (AVS_BYTEENABLE[1:0] == 2'b11) begin
                if (AVS_WRITEDATA[15:0] < {6'h00, vr_ctl_pkg::PER_MIN}) begin
                    period_next = vr_ctl_pkg::PER_MIN;
                end else if (AVS_WRITEDATA[15:0] > {6'h00, vr_ctl_pkg::PER_MAX}) begin
                    period_next = vr_ctl_pkg::PER_MAX;
                end else begin
                    period_next = AVS_WRITEDATA[PW-1:0];
                end
            end
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdata_reg <= '0;
            period_reg <= vr_ctl_pkg::PER_RESET;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            period_reg <= period_next;
        end
    end

    assign AVS_WAITREQUEST = req && !ack_reg;
    assign AVS_READDATA = rdata_reg;
    assign GATE_O = gate_o_reg;
    assign GATE_OE = gate_oe_reg;
    assign BRIDGE_O = bridge_o_reg;
    assign BRIDGE_OE = bridge_oe_reg;
    assign POWER_GOOD_OUT = pgood_reg;
    assign CORE_TARGET = target_reg;
endmodule // vr_mode_startup
`default_nettype wire

// >>> vr_mode_startup_asserts.sv
// port checks of the regulator control block
`default_nettype none
module vr_mode_startup_asserts (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic ENABLE,
    input wire logic [5:0] PARALLEL_CODE_BUS,
    input wire logic [1:0] GATE_SENSE_I,
    input wire logic [3:0] GATE_O,
    input wire logic [3:0] GATE_OE,
    input wire logic BRIDGE_OE,
    input wire logic POWER_GOOD_OUT,
    input wire logic [vr_ctl_pkg::TGT_W-1:0] CORE_TARGET
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);
    logic en_reg, par_reg;
    logic [1:0] sense_reg;
    logic [vr_ctl_pkg::TGT_W-1:0] prev_reg;
    logic [15:0] cnt_reg;
    logic [3:0] oe_exp;
    // pins held steady, so pin-edge values are what the core samples
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            en_reg <= 1'b0;
            par_reg <= 1'b0;
            sense_reg <= 2'b00;
            prev_reg <= '0;
            cnt_reg <= 16'h0000;
        end else begin
            en_reg <= ENABLE;
            if (ENABLE && !en_reg) begin
                par_reg <= PARALLEL_CODE_BUS[1];
                sense_reg <= GATE_SENSE_I;
            end
            prev_reg <= CORE_TARGET;
            cnt_reg <= (CORE_TARGET != prev_reg) ? 16'h0000 : cnt_reg + 16'h0001;
        end
    end
    assign oe_exp = sense_reg[1] ? 4'hF : (sense_reg[0] ? 4'h7 : 4'h3);
    sequence enable_drop_s;
        $fell(ENABLE);
    endsequence
    sequence core_idle_s;
        !POWER_GOOD_OUT && CORE_TARGET == '0 && GATE_OE == 4'h0;
    endsequence
    idle_drop_a: assert property (enable_drop_s |-> ##[2:6] core_idle_s)
        else $error("not idle after disable");
    pgood_after_ramp_a: assert property ($rose(POWER_GOOD_OUT) |->
        CORE_TARGET != '0 && $stable(CORE_TARGET) && GATE_OE != 4'h0)
        else $error("early power good");
    single_step_a: assert property (CORE_TARGET != prev_reg && CORE_TARGET != '0 |->
        CORE_TARGET == prev_reg + 1'b1 || (POWER_GOOD_OUT && CORE_TARGET + 1'b1 == prev_reg))
        else $error("target jump");
    step_time_a: assert property (CORE_TARGET != prev_reg && prev_reg != '0 &&
        CORE_TARGET != '0 && !POWER_GOOD_OUT |-> cnt_reg == 16'h0063)
        else $error("step spacing");
    bridge_hiz_a: assert property (par_reg |-> !BRIDGE_OE)
        else $error("bridge driven in parallel");
    bridge_serial_a: assert property (!par_reg && POWER_GOOD_OUT |-> BRIDGE_OE)
        else $error("bridge idle in serial");
    phase_count_a: assert property (POWER_GOOD_OUT |-> GATE_OE == oe_exp)
        else $error("gate enables wrong");
    gate_strobe_a: assert property ((GATE_O & ~GATE_OE) == 4'h0 &&
        (GATE_O & $past(GATE_O)) == 4'h0)
        else $error("stray gate start");
endmodule // vr_mode_startup_asserts
bind vr_mode_startup vr_mode_startup_asserts chk_i (
    .MCLK(MCLK), .ARST_N(ARST_N), .ENABLE(ENABLE), .PARALLEL_CODE_BUS(PARALLEL_CODE_BUS),
    .GATE_SENSE_I(GATE_SENSE_I), .GATE_O(GATE_O), .GATE_OE(GATE_OE), .BRIDGE_OE(BRIDGE_OE),
    .POWER_GOOD_OUT(POWER_GOOD_OUT), .CORE_TARGET(CORE_TARGET)
);
`default_nettype wire

// >>> host_seq_model.sv
// processor code lines, power sequencing and board gate straps
`default_nettype none
module host_seq_model (
    input wire logic clk,
    input wire logic want_en,
    input wire logic [5:0] want_code,
    input wire logic want_psave,
    input wire logic want_ok,
    input wire logic [1:0] grounded,
    input wire logic [3:0] gate_o,
    input wire logic [3:0] gate_oe,
    output logic enable,
    output logic [5:0] code_bus,
    output logic psave,
    output logic host_ok,
    output logic [1:0] gate_sense
);
    // released gate pins pull up unless strapped low
    assign gate_sense[0] = gate_oe[1] ? gate_o[1] : ~grounded[0];
    assign gate_sense[1] = gate_oe[3] ? gate_o[3] : ~grounded[1];
    initial begin
        enable = 1'b0;
        code_bus = 6'h00;
        psave = 1'b0;
        host_ok = 1'b0;
        forever begin
            @(posedge clk);
            // lines settle before enable moves
            if (code_bus !== want_code || psave !== want_psave) begin
                code_bus <= want_code;
                psave <= want_psave;
            end else begin
                enable <= want_en;
            end
            host_ok <= want_ok;
        end
    end
endmodule // host_seq_model
`default_nettype wire

// >>> vr_mode_startup_tb.sv
// self-checking bench of the regulator control block
`default_nettype none
module vr_mode_startup_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 80000;
    logic MCLK = 1'b0, ARST_N = 1'b0, want_en = 1'b0, want_psave = 1'b0, want_ok = 1'b0;
    logic [5:0] want_code = 6'h00;
    logic [1:0] grounded = 2'b00;
    logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'h0;
    logic AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
    logic ENABLE, POWER_SAVING_STRAP, HOST_POWER_OK, BRIDGE_O, BRIDGE_OE, POWER_GOOD_OUT;
    logic AVS_WAITREQUEST;
    logic [5:0] PARALLEL_CODE_BUS;
    logic [1:0] GATE_SENSE_I;
    logic [3:0] GATE_O, GATE_OE;
    logic [7:0] CORE_TARGET;
    logic [31:0] AVS_READDATA;
    logic [4:0] strobes;
    int error_cnt = 0, checked = 0, cycles = 0;
    assign strobes = {BRIDGE_O, GATE_O};
    host_seq_model host (
        .clk(MCLK), .want_en(want_en), .want_code(want_code), .want_psave(want_psave),
        .want_ok(want_ok), .grounded(grounded), .gate_o(GATE_O), .gate_oe(GATE_OE),
        .enable(ENABLE), .code_bus(PARALLEL_CODE_BUS), .psave(POWER_SAVING_STRAP),
        .host_ok(HOST_POWER_OK), .gate_sense(GATE_SENSE_I)
    );
    vr_mode_startup dut (
        .MCLK(MCLK), .ARST_N(ARST_N), .ENABLE(ENABLE), .PARALLEL_CODE_BUS(PARALLEL_CODE_BUS),
        .POWER_SAVING_STRAP(POWER_SAVING_STRAP), .HOST_POWER_OK(HOST_POWER_OK),
        .GATE_SENSE_I(GATE_SENSE_I), .GATE_O(GATE_O), .GATE_OE(GATE_OE), .BRIDGE_O(BRIDGE_O),
        .BRIDGE_OE(BRIDGE_OE), .POWER_GOOD_OUT(POWER_GOOD_OUT), .CORE_TARGET(CORE_TARGET),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST)
    );
    initial begin
        forever #5 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            error_cnt++;
            results();
        end
    end
    task automatic results();
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] exp_par(input logic [5:0] c);
        if (c < 6'h20) return vr_ctl_pkg::PAR_HI_BASE - {1'b0, c, 1'b0};
        return vr_ctl_pkg::PAR_LO_BASE - {2'b00, c - 6'h20};
    endfunction
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        AVS_WRITE <= wr;
        AVS_READ <= ~wr;
        @(posedge MCLK iff AVS_WAITREQUEST === 1'b0);
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge MCLK);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, e,
                          input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, 4'hF, q);
        chk(what, e, q & m);
    endtask
    task automatic start(input logic [5:0] c, input logic [1:0] g, input logic ps, ok);
        want_code <= c;
        grounded <= g;
        want_psave <= ps;
        want_ok <= ok;
        repeat (4) @(posedge MCLK);
        want_en <= 1'b1;
    endtask
    task automatic stop();
        want_en <= 1'b0;
        repeat (8) @(posedge MCLK);
        chk("idle outputs", 32'h0000_0000, {POWER_GOOD_OUT, GATE_OE, CORE_TARGET});
    endtask
    task automatic settle(input logic [7:0] t, input int lim, input string what);
        while (!(POWER_GOOD_OUT === 1'b1 && CORE_TARGET === t) && lim > 0) begin
            @(posedge MCLK);
            lim--;
        end
        chk(what, {1'b1, t}, {POWER_GOOD_OUT, CORE_TARGET});
    endtask
    task automatic gap(input int a, input int b, output int n);
        n = 0;
        @(posedge MCLK iff strobes[a] === 1'b1);
        do begin
            @(posedge MCLK);
            n++;
        end while (strobes[b] !== 1'b1);
    endtask
    task automatic test_regs();
        logic [3:0] p;
        logic [31:0] m;
        p = vr_ctl_pkg::OFS_PERIOD;
        m = 32'h0000_03FF;
        chk("outputs after reset", 32'h0000_0000,
            {POWER_GOOD_OUT, BRIDGE_OE, GATE_OE, CORE_TARGET});
        rd_chk(p, m, 32'h0000_0190, "period reset");
        wr(p, 32'h0000_03FF, 4'hF);
        rd_chk(p, m, 32'h0000_03E8, "period high");
        wr(p, 32'h0000_0032, 4'hF);
        rd_chk(p, m, 32'h0000_0064, "period low");
        wr(p, 32'h0000_0190, 4'hC);
        rd_chk(p, m, 32'h0000_0064, "period partial");
        wr(4'hC, 32'hFFFF_FFFF, 4'hF);
        rd_chk(4'hC, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
        wr(vr_ctl_pkg::OFS_TARGET, 32'h0000_00FF, 4'hF);
        rd_chk(vr_ctl_pkg::OFS_TARGET, 32'h0000_00FF, 32'h0000_0000, "target readonly");
    endtask
    task automatic test_parallel();
        int n;
        wr(vr_ctl_pkg::OFS_PERIOD, 32'h0000_00C8, 4'hF);
        start(6'h3F, 2'b10, 1'b1, 1'b0);
        settle(exp_par(6'h3F), 4000, "parallel startup");
        chk("parallel gates", 32'h0000_0007, {BRIDGE_OE, GATE_OE});
        rd_chk(vr_ctl_pkg::OFS_STATUS, 32'h00FF_FFFF, 32'h001E_1E2F, "status");
        gap(0, 1, n);
        chk("three phase gap", 32'h0000_0042, n);
        want_ok <= 1'b1;
        repeat (20) @(posedge MCLK);
        want_ok <= 1'b0;
        repeat (20) @(posedge MCLK);
        chk("power good", 32'h0000_0001, POWER_GOOD_OUT);
        want_code <= 6'h2A;
        settle(exp_par(6'h2A), 2600, "tracked code");
        want_code <= 6'h1F;
        settle(exp_par(6'h1F), 1500, "tracked code");
        stop();
    endtask
    task automatic test_serial();
        logic [7:0] boot [4];
        int n;
        boot = '{vr_ctl_pkg::BOOT_00, vr_ctl_pkg::BOOT_01, vr_ctl_pkg::BOOT_10,
                 vr_ctl_pkg::BOOT_11};
        wr(vr_ctl_pkg::OFS_PERIOD, 32'h0000_0190, 4'hF);
        for (int i = 0; i < 4; i++) begin
            start({2'b00, i[0], i[1], 2'b00}, 2'b11, 1'b0, 1'b1);
            settle(boot[i], 10000, "serial startup");
            rd_chk(vr_ctl_pkg::OFS_STATUS, 32'h00FF_00FF, {8'h00, boot[i], 16'h00CA},
                   "serial status");
            if (i < 3) stop();
        end
        gap(0, 1, n);
        chk("two phase gap", 32'h0000_00C8, n);
        gap(4, 4, n);
        chk("bridge period", 32'h0000_0140, n);
        want_code <= 6'h3D;
        repeat (300) @(posedge MCLK);
        chk("serial target", vr_ctl_pkg::BOOT_11, CORE_TARGET);
        stop();
    endtask
    task automatic test_abort();
        int n;
        wr(vr_ctl_pkg::OFS_PERIOD, 32'h0000_0064, 4'hF);
        start(6'h3F, 2'b00, 1'b0, 1'b0);
        repeat (400) @(posedge MCLK);
        chk("four phase ramp", 32'h0000_000F, {POWER_GOOD_OUT, BRIDGE_OE, GATE_OE});
        gap(0, 1, n);
        chk("four phase gap", 32'h0000_0019, n);
        stop();
    endtask
    initial begin
        repeat (20) @(posedge MCLK);
        ARST_N <= 1'b1;
        repeat (5) @(posedge MCLK);
        test_regs();
        test_parallel();
        test_serial();
        test_abort();
        results();
    end
endmodule // vr_mode_startup_tb
`default_nettype wire
